// file: rtl/ssc_pkg.sv
// package for the stop mode standby controller
`default_nettype none
package ssc_pkg;
   localparam int unsigned CLK_MHZ = 200;
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAB_SEL = 8'h04;
   localparam logic [7:0] REG_STAB_CNT = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_CMD = 8'h10;
   // ctrl fields
   localparam int CTRL_HS_STOP = 0;
   localparam int CTRL_MAIN_SEL = 1;
   localparam int CTRL_HIGH_AMP = 2;
   localparam int CTRL_LS_STOP = 3;
   localparam int CTRL_EXT_CLK = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // cmd fields
   localparam int CMD_STOP = 0;
   localparam int CMD_HALT = 1;
   // status fields
   localparam int ST_MAIN_STAT = 0;
   localparam int ST_HS_RUN = 1;
   localparam int ST_CPU_CLK = 2;
   localparam int ST_MODE_LSB = 4;
   localparam int ST_LS_RUN = 8;
   localparam logic [2:0] STAB_SEL_RESET = 3'h5;
   localparam int unsigned STAB_BASE_LOG2 = 8;
   // high amplitude hold-off: minimum figure in ns, rounded up
   localparam int unsigned AMP_HOLD_NS = 4060;
   localparam int unsigned AMP_HOLD_CYC = (AMP_HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned AMP_EXT_CYC = 160;
   localparam int unsigned CNT_W = 20;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   typedef enum logic [4:0]
   {
      ST_RUN = 5'h01,
      ST_STOP = 5'h02,
      ST_HALT = 5'h04,
      ST_STAB = 5'h08,
      ST_AMPW = 5'h10
   } ssc_state_type;
endpackage : ssc_pkg
`default_nettype wire

// file: rtl/ssc_if.sv
// interface carrying the register view between slave and core
`default_nettype none
interface ssc_reg_if;
   logic [31:0] ctrl;
   logic [2:0] stab_sel;
   logic stop_cmd;
   logic halt_cmd;
   logic [31:0] status;
   logic [31:0] stab_cnt;
   modport slave (output ctrl, output stab_sel, output stop_cmd, output halt_cmd,
      input status, input stab_cnt);
   modport core (input ctrl, input stab_sel, input stop_cmd, input halt_cmd,
      output status, output stab_cnt);
endinterface : ssc_reg_if
`default_nettype wire

// file: rtl/ssc_axi_regs.sv
// axi4-lite register slave for the standby controller
`default_nettype none
module ssc_axi_regs
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [7:0] awaddr_in,
   input wire logic awvalid_in,
   output logic awready_out,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] wstrb_in,
   input wire logic wvalid_in,
   output logic wready_out,
   output logic [1:0] bresp_out,
   output logic bvalid_out,
   input wire logic bready_in,
   input wire logic [7:0] araddr_in,
   input wire logic arvalid_in,
   output logic arready_out,
   output logic [31:0] rdata_out,
   output logic [1:0] rresp_out,
   output logic rvalid_out,
   input wire logic rready_in,
   ssc_reg_if.slave regs
);
   import ssc_pkg::*;
   logic aw_ok_q, aw_ok_d, w_ok_q, w_ok_d, bv_q, bv_d, rv_q, rv_d;
   logic [7:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d, ctrl_q, ctrl_d;
   logic [3:0] ws_q, ws_d;
   logic [1:0] br_q, br_d, rr_q, rr_d;
   logic [2:0] sel_q, sel_d;
   logic stop_d, stop_q, halt_d, halt_q, do_wr;
   assign awready_out = !aw_ok_q && !bv_q;
   assign wready_out = !w_ok_q && !bv_q;
   assign arready_out = !rv_q;
   assign bvalid_out = bv_q;
   assign bresp_out = br_q;
   assign rvalid_out = rv_q;
   assign rdata_out = rd_q;
   assign rresp_out = rr_q;
   assign regs.ctrl = ctrl_q;
   assign regs.stab_sel = sel_q;
   assign regs.stop_cmd = stop_q;
   assign regs.halt_cmd = halt_q;
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
      input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (st[i])
         begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge
   always_comb
   begin
      aw_ok_d = aw_ok_q;
      w_ok_d = w_ok_q;
      awa_d = awa_q;
      wd_d = wd_q;
      ws_d = ws_q;
      bv_d = bv_q;
      br_d = br_q;
      rv_d = rv_q;
      rd_d = rd_q;
      rr_d = rr_q;
      ctrl_d = ctrl_q;
      sel_d = sel_q;
      stop_d = 1'b0;
      halt_d = 1'b0;
      if (awvalid_in && awready_out)
      begin
         aw_ok_d = 1'b1;
         awa_d = awaddr_in;
      end
      if (wvalid_in && wready_out)
      begin
         w_ok_d = 1'b1;
         wd_d = wdata_in;
         ws_d = wstrb_in;
      end
      do_wr = aw_ok_q && w_ok_q && !bv_q;
      if (do_wr)
      begin
         aw_ok_d = 1'b0;
         w_ok_d = 1'b0;
         bv_d = 1'b1;
         br_d = AXI_OKAY;
         case (awa_q)
            REG_CTRL: ctrl_d = merge(ctrl_q, wd_q, ws_q);
            REG_STAB_SEL: if (ws_q[0]) sel_d = wd_q[2:0];
            REG_CMD:
            begin
               stop_d = ws_q[0] && wd_q[CMD_STOP];
               halt_d = ws_q[0] && wd_q[CMD_HALT];
            end
            REG_STATUS, REG_STAB_CNT: ;
            default: br_d = AXI_SLVERR;
         endcase
      end
      if (bv_q && bready_in)
      begin
         bv_d = 1'b0;
      end
      if (rv_q && rready_in)
      begin
         rv_d = 1'b0;
      end
      if (arvalid_in && arready_out)
      begin
         rv_d = 1'b1;
         rr_d = AXI_OKAY;
         case (araddr_in)
            REG_CTRL: rd_d = ctrl_q;
            REG_STAB_SEL: rd_d = {29'h0000_0000, sel_q};
            REG_STAB_CNT: rd_d = regs.stab_cnt;
            REG_STATUS: rd_d = regs.status;
            REG_CMD: rd_d = 32'h0000_0000;
            default:
            begin
               rd_d = 32'h0000_0000;
               rr_d = AXI_SLVERR;
            end
         endcase
      end
   end
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         aw_ok_q <= 1'b0;
         w_ok_q <= 1'b0;
         awa_q <= 8'h00;
         wd_q <= 32'h0000_0000;
         ws_q <= 4'h0;
         bv_q <= 1'b0;
         br_q <= 2'h0;
         rv_q <= 1'b0;
         rd_q <= 32'h0000_0000;
         rr_q <= 2'h0;
         ctrl_q <= CTRL_RESET;
         sel_q <= STAB_SEL_RESET;
         stop_q <= 1'b0;
         halt_q <= 1'b0;
      end
      else
      begin
         aw_ok_q <= aw_ok_d;
         w_ok_q <= w_ok_d;
         awa_q <= awa_d;
         wd_q <= wd_d;
         ws_q <= ws_d;
         bv_q <= bv_d;
         br_q <= br_d;
         rv_q <= rv_d;
         rd_q <= rd_d;
         rr_q <= rr_d;
         ctrl_q <= ctrl_d;
         sel_q <= sel_d;
         stop_q <= stop_d;
         halt_q <= halt_d;
      end
   end
endmodule : ssc_axi_regs
`default_nettype wire

// file: rtl/ssc_top.sv
// stop mode standby controller top
// Operation
// RULE1 - the crystal wait counts only after the crystal actually oscillates.
// RULE2 - stop with an unmasked pending interrupt drops straight into halt.
// RULE3 - after that drop, run resumes only after the selected wait elapses; the code skips it unless the crystal is selected and CTRL_EXT_CLK is clear.
// RULE4 - software restarts peripherals stopped by stop after release.
// RULE5 - the low-speed oscillator keeps its pre-stop state through stop.
// RULE6 - to halt the low-speed oscillator in stop, software stops it first.
// RULE7 - software moves the cpu clock to the internal oscillator before stop.
// RULE8 - software checks the counter status before returning to the crystal.
// RULE9 - with high amplitude set, the cpu clock is withheld after release.
// RULE10 - software issues stop only once the internal oscillator runs.
// RULE11 - an external reset is held low at least 10 us.
// RULE12 - a crystal wait gates the cpu clock until the counter hits the select.
//
// Added by the designer: register access over AXI4-Lite and the address map.
`default_nettype none
module ssc_top
#(
   parameter int unsigned AMP_HOLD = ssc_pkg::AMP_HOLD_CYC,
   parameter int unsigned EXT_HOLD = ssc_pkg::AMP_EXT_CYC
)
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [7:0] awaddr_in,
   input wire logic awvalid_in,
   output logic awready_out,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] wstrb_in,
   input wire logic wvalid_in,
   output logic wready_out,
   output logic [1:0] bresp_out,
   output logic bvalid_out,
   input wire logic bready_in,
   input wire logic [7:0] araddr_in,
   input wire logic arvalid_in,
   output logic arready_out,
   output logic [31:0] rdata_out,
   output logic [1:0] rresp_out,
   output logic rvalid_out,
   input wire logic rready_in,
   input wire logic irq_pending_in,
   input wire logic main_crystal_clock_in,
   input wire logic hs_osc_stable_in,
   output logic cpu_clk_en_out,
   output logic periph_clk_en_out,
   output logic crystal_en_out,
   output logic hs_osc_en_out,
   output logic ls_osc_en_out,
   output logic [4:0] mode_out
);
   import ssc_pkg::*;
   ssc_reg_if rif ();
   ssc_axi_regs i_ssc_axi_regs
   (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .awaddr_in(awaddr_in),
      .awvalid_in(awvalid_in),
      .awready_out(awready_out),
      .wdata_in(wdata_in),
      .wstrb_in(wstrb_in),
      .wvalid_in(wvalid_in),
      .wready_out(wready_out),
      .bresp_out(bresp_out),
      .bvalid_out(bvalid_out),
      .bready_in(bready_in),
      .araddr_in(araddr_in),
      .arvalid_in(arvalid_in),
      .arready_out(arready_out),
      .rdata_out(rdata_out),
      .rresp_out(rresp_out),
      .rvalid_out(rvalid_out),
      .rready_in(rready_in),
      .regs(rif.slave)
   );
   ssc_state_type st_q, st_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [CNT_W-1:0] amp_q, amp_d;
   logic ls_q, ls_d;
   logic main_sel_q, main_sel_d;
   logic xtal_q, xtal_d;
   logic [CNT_W-1:0] target;
   logic hs_on, use_xtal, stab_done;
   function automatic logic [CNT_W-1:0] stab_target(input logic [2:0] sel);
      return CNT_W'(1) << (STAB_BASE_LOG2 + 32'(sel));
   endfunction : stab_target
   assign target = stab_target(rif.stab_sel);
   assign hs_on = !rif.ctrl[CTRL_HS_STOP];
   assign use_xtal = main_sel_q && !rif.ctrl[CTRL_EXT_CLK];
   assign stab_done = cnt_q >= target;
   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_q;
      amp_d = amp_q;
      ls_d = ls_q;
      main_sel_d = main_sel_q;
      xtal_d = 1'b1;
      // software may only toggle the low-speed osc in run
      if (st_q == ST_RUN)
      begin
         ls_d = !rif.ctrl[CTRL_LS_STOP]; // [RULE5] [RULE6]
         if (rif.ctrl[CTRL_MAIN_SEL] && stab_done)
         begin
            main_sel_d = 1'b1; // [RULE8]
         end
         if (!rif.ctrl[CTRL_MAIN_SEL])
         begin
            main_sel_d = 1'b0;
         end
      end
      // counter runs only while the crystal is seen oscillating
      if (main_crystal_clock_in && !stab_done)
      begin
         cnt_d = cnt_q + CNT_W'(1); // [RULE1]
      end
      case (st_q)
         ST_RUN:
         begin
            if (rif.stop_cmd)
            begin
               cnt_d = '0;
               if (irq_pending_in)
               begin
                  st_d = ST_HALT; // [RULE2]
               end
               else
               begin
                  st_d = ST_STOP;
               end
            end
            else if (rif.halt_cmd)
            begin
               st_d = ST_HALT;
            end
         end
         ST_STOP:
         begin
            xtal_d = 1'b0;
            cnt_d = '0;
            if (irq_pending_in)
            begin
               st_d = ST_STAB;
            end
         end
         ST_HALT:
         begin
            if (irq_pending_in)
            begin
               st_d = ST_STAB;
            end
         end
         ST_STAB:
         begin
            if (!use_xtal || stab_done)
            begin
               // wait elapsed or crystal not in use, apply high amplitude hold-off if set
               if (rif.ctrl[CTRL_HIGH_AMP])
               begin
                  st_d = ST_AMPW; // [RULE9]
                  amp_d = rif.ctrl[CTRL_EXT_CLK] ? CNT_W'(EXT_HOLD) : CNT_W'(AMP_HOLD);
               end
               else
               begin
                  st_d = ST_RUN; // [RULE3]
               end
            end
         end
         ST_AMPW:
         begin
            if (amp_q <= CNT_W'(1))
            begin
               st_d = ST_RUN;
               amp_d = '0;
            end
            else
            begin
               amp_d = amp_q - CNT_W'(1); // [RULE9]
            end
         end
         default: st_d = ST_RUN;
      endcase
   end
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         st_q <= ST_RUN;
         cnt_q <= '0;
         amp_q <= '0;
         ls_q <= 1'b1;
         main_sel_q <= 1'b0;
         xtal_q <= 1'b1;
      end
      else
      begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         amp_q <= amp_d;
         ls_q <= ls_d;
         main_sel_q <= main_sel_d;
         xtal_q <= xtal_d;
      end
   end
   // cpu clock gated in stop, halt, crystal wait and hold-off
   assign cpu_clk_en_out = (st_q == ST_RUN); // [RULE12]
   assign periph_clk_en_out = (st_q != ST_STOP);
   assign crystal_en_out = xtal_q;
   assign hs_osc_en_out = hs_on;
   assign ls_osc_en_out = ls_q;
   assign mode_out = st_q;
   assign rif.stab_cnt = 32'(cnt_q);
   always_comb
   begin
      rif.status = '0;
      rif.status[ST_MAIN_STAT] = main_sel_q;
      rif.status[ST_HS_RUN] = hs_on && hs_osc_stable_in;
      rif.status[ST_CPU_CLK] = st_q == ST_RUN;
      rif.status[ST_MODE_LSB +: 4] = st_q[4:1];
      rif.status[ST_LS_RUN] = ls_q;
   end
endmodule : ssc_top
`default_nettype wire

// file: verif/ssc_monitor.sv
// assertion checker for the standby controller
`default_nettype none
module ssc_monitor
#(
   parameter int unsigned AMP_HOLD = 8,
   parameter int unsigned EXT_HOLD = 8
)
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic irq_pending_in,
   input wire logic cpu_clk_en_out,
   input wire logic ls_osc_en_out,
   input wire logic [4:0] mode_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned amp_cnt_q;
   int unsigned amp_cnt_d;
   always_comb amp_cnt_d = (mode_out == 5'h10) ? amp_cnt_q + 1 : 0;
   always_ff @(posedge clk_in) amp_cnt_q <= rst_in ? 0 : amp_cnt_d;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   property p_irq_wake;
      (mode_out == 5'h02 && irq_pending_in) |=> mode_out == 5'h08;
   endproperty
   a_irq_wake: assert property (p_irq_wake) else $error("stop ignored wake");
   property p_halt_exit;
      mode_out == 5'h04 |=> mode_out inside {5'h04, 5'h08};
   endproperty
   a_halt_exit: assert property (p_halt_exit) else $error("halt skipped wait");
   property p_clk_gate;
      cpu_clk_en_out == (mode_out == 5'h01);
   endproperty
   a_clk_gate: assert property (p_clk_gate) else $error("cpu clock outside run");
   property p_ls_hold;
      mode_out != 5'h01 |=> $stable(ls_osc_en_out);
   endproperty
   a_ls_hold: assert property (p_ls_hold) else $error("low-speed osc moved");
   property p_amp_len;
      $fell(mode_out[4]) |-> mode_out == 5'h01 && amp_cnt_q inside {AMP_HOLD, EXT_HOLD};
   endproperty
   a_amp_len: assert property (p_amp_len) else $error("hold-off length wrong");
   property p_stab_exit;
      mode_out == 5'h08 |=> mode_out inside {5'h08, 5'h01, 5'h10};
   endproperty
   a_stab_exit: assert property (p_stab_exit) else $error("bad exit from wait");
endmodule : ssc_monitor
bind ssc_top ssc_monitor #(.AMP_HOLD(AMP_HOLD), .EXT_HOLD(EXT_HOLD)) i_ssc_monitor
(
   .clk_in(clk_in),
   .rst_in(rst_in),
   .irq_pending_in(irq_pending_in),
   .cpu_clk_en_out(cpu_clk_en_out),
   .ls_osc_en_out(ls_osc_en_out),
   .mode_out(mode_out)
);
`default_nettype wire

// file: verif/ssc_env_model.sv
// crystal and interrupt source model facing the controller
`default_nettype none
module ssc_env_model
#(
   parameter int unsigned XTAL_START = 40
)
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic crystal_en_in,
   input wire logic irq_req_in,
   input wire logic irq_mask_in,
   output logic irq_pending_out,
   output logic xtal_osc_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned start_q;
   assign irq_pending_out = irq_req_in & ~irq_mask_in;
   // oscillation only shows after a start-up delay
   always @(posedge clk_in)
      start_q <= (rst_in || !crystal_en_in) ? 0 : start_q + (start_q < XTAL_START);
   assign xtal_osc_out = (start_q >= XTAL_START);
endmodule : ssc_env_model
`default_nettype wire

// file: verif/ssc_top_tb.sv
// self-checking bench for the standby controller
`default_nettype none
module ssc_top_tb;
   import ssc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in, rst_in, awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in;
   logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out, cpu_clk_en_out;
   logic periph_clk_en_out, crystal_en_out, hs_osc_en_out, ls_osc_en_out, saw_halt;
   logic irq_pending_in, main_crystal_clock_in, hs_osc_stable_in, irq_req, irq_mask;
   logic [7:0] awaddr_in, araddr_in;
   logic [31:0] wdata_in, rdata_out, rd;
   logic [3:0] wstrb_in;
   logic [1:0] bresp_out, rresp_out, rsp;
   logic [4:0] mode_out;
   int n_mismatch = 0;
   int total_checks = 0;
   int cyc, ampw;
   ssc_top #(.AMP_HOLD(8), .EXT_HOLD(12)) i_ssc_top
   (
      .clk_in(clk_in), .rst_in(rst_in), .awaddr_in(awaddr_in), .awvalid_in(awvalid_in),
      .awready_out(awready_out), .wdata_in(wdata_in), .wstrb_in(wstrb_in),
      .wvalid_in(wvalid_in), .wready_out(wready_out), .bresp_out(bresp_out),
      .bvalid_out(bvalid_out), .bready_in(bready_in), .araddr_in(araddr_in),
      .arvalid_in(arvalid_in), .arready_out(arready_out), .rdata_out(rdata_out),
      .rresp_out(rresp_out), .rvalid_out(rvalid_out), .rready_in(rready_in),
      .irq_pending_in(irq_pending_in), .main_crystal_clock_in(main_crystal_clock_in),
      .hs_osc_stable_in(hs_osc_stable_in), .cpu_clk_en_out(cpu_clk_en_out),
      .periph_clk_en_out(periph_clk_en_out), .crystal_en_out(crystal_en_out),
      .hs_osc_en_out(hs_osc_en_out), .ls_osc_en_out(ls_osc_en_out), .mode_out(mode_out)
   );
   ssc_env_model #(.XTAL_START(40)) i_ssc_env_model (.clk_in(clk_in), .rst_in(rst_in),
      .crystal_en_in(crystal_en_out), .irq_req_in(irq_req), .irq_mask_in(irq_mask),
      .irq_pending_out(irq_pending_in), .xtal_osc_out(main_crystal_clock_in));
   assign hs_osc_stable_in = hs_osc_en_out;
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   task automatic chk_ge(input string what, input int lo, input int got);
      chk(what, 32'h1, 32'(got >= lo));
   endtask : chk_ge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tk;
      tk = 0;
      awaddr_in <= a;
      wdata_in <= d;
      awvalid_in <= 1'h1;
      wvalid_in <= 1'h1;
      bready_in <= 1'h1;
      repeat (100)
      if (!tk)
      begin
         @(negedge clk_in);
         ta = awvalid_in & awready_out;
         tw = wvalid_in & wready_out;
         tk = bvalid_out & bready_in;
         rsp = bresp_out;
         @(posedge clk_in);
         if (ta) awvalid_in <= 1'h0;
         if (tw) wvalid_in <= 1'h0;
      end
      chk("write answer", 32'h1, 32'(tk));
      if (!tk) end_sim();
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      logic ta, tk;
      tk = 0;
      araddr_in <= a;
      arvalid_in <= 1'h1;
      rready_in <= 1'h1;
      repeat (100)
      if (!tk)
      begin
         @(negedge clk_in);
         ta = arvalid_in & arready_out;
         tk = rvalid_out & rready_in;
         rd = rdata_out;
         rsp = rresp_out;
         @(posedge clk_in);
         if (ta) arvalid_in <= 1'h0;
      end
      chk("read answer", 32'h1, 32'(tk));
      if (!tk) end_sim();
   endtask : rdr
   task automatic wait_run();
      logic done;
      done = 0;
      cyc = 0;
      ampw = 0;
      saw_halt = 0;
      @(negedge clk_in);
      repeat (4) if (mode_out === 5'h01) @(negedge clk_in);
      repeat (3000)
      if (!done)
      begin
         saw_halt |= (mode_out === 5'h04);
         ampw += (mode_out === 5'h10);
         done = (mode_out === 5'h01);
         cyc += !done;
         if (!done) @(negedge clk_in);
      end
      @(posedge clk_in);
      chk("back in run", 32'h1, 32'(done));
      if (!done) end_sim();
   endtask : wait_run
   initial
   begin
      clk_in = 0;
      forever #2.5 clk_in = ~clk_in;
   end
   initial
   begin
      {rst_in, awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in} = 6'h20;
      {awaddr_in, araddr_in, wdata_in, irq_req, irq_mask} = 0;
      wstrb_in = 4'hF;
      repeat (10) @(posedge clk_in);
      rst_in <= 1'h0;
      @(posedge clk_in);
      rdr(REG_CTRL);
      chk("ctrl", 32'h0, rd);
      rdr(REG_STAB_SEL);
      chk("stab sel", 32'h5, rd);
      rdr(REG_STATUS);
      chk("status", 32'h106, rd);
      rdr(8'h20);
      chk("unmapped resp", 32'h2, 32'(rsp));
      chk("unmapped data", 32'h0, rd);
      wr(REG_STAB_SEL, 32'h0);
      wr(REG_CTRL, 32'h2);
      repeat (320) @(posedge clk_in);
      rdr(REG_STATUS);
      chk("crystal selected", 32'h1, rd & 32'h1);
      irq_req <= 1'h1;
      wr(REG_CMD, 32'h1);
      wait_run();
      chk("dropped to halt", 32'h1, 32'(saw_halt));
      chk_ge("wait cycles", 256, cyc);
      irq_req <= 1'h0;
      rdr(REG_STAB_CNT);
      chk("counter", 32'd256, rd);
      wr(REG_CMD, 32'h1);
      irq_req <= 1'h1;
      irq_mask <= 1'h1;
      repeat (20) @(posedge clk_in);
      chk("masked stays stopped", 32'h2, 32'(mode_out));
      chk("periph clock off", 32'h0, 32'(periph_clk_en_out));
      chk("crystal off", 32'h0, 32'(crystal_en_out));
      wr(REG_CTRL, 32'hA);
      repeat (2) @(posedge clk_in);
      chk("low-speed held", 32'h1, 32'(ls_osc_en_out));
      irq_mask <= 1'h0;
      wait_run();
      chk_ge("start-up excluded", 296, cyc);
      @(posedge clk_in);
      chk("low-speed stopped", 32'h0, 32'(ls_osc_en_out));
      irq_req <= 1'h0;
      for (int i = 0; i < 2; i++)
      begin
         wr(REG_CTRL, i ? 32'h14 : 32'h4);
         rdr(REG_STATUS);
         chk("status low bits", 32'h2, rd & 32'h3);
         chk("hs osc on", 32'h1, 32'(hs_osc_en_out));
         irq_req <= 1'h1;
         wr(REG_CMD, 32'h1);
         wait_run();
         chk("hold-off", i ? 32'd12 : 32'd8, 32'(ampw));
         irq_req <= 1'h0;
      end
      wr(REG_CMD, 32'h2);
      repeat (5) @(posedge clk_in);
      chk("halt command", 32'h4, 32'(mode_out));
      irq_req <= 1'h1;
      wait_run();
      chk("halt released", 32'h1, 32'(saw_halt));
      chk("halt hold-off", 32'd12, 32'(ampw));
      irq_req <= 1'h0;
      end_sim();
   end
endmodule : ssc_top_tb
`default_nettype wire
